/* verilog/adr_pkg.sv */
// shared constants for the result readout port, both ends
// assumes: both ends run on 125 MHz clocks; the link pins cross between them
`default_nettype none

package adr_pkg;
	// ----------------------------------------------------------------
	// result layout
	// ----------------------------------------------------------------
	localparam int NUM_CH = 4;
	localparam int RES_W = 16;
	localparam int BYTE_W = 8;
	localparam logic [2:0] BYTE_CNT_RST = 3'h0;
	localparam logic [2:0] BYTE_CNT_FIRST_LOW = 3'h2; // third strobe drops the flag
	localparam logic [5:0] BIT_PTR_RST = 6'h00;
	localparam logic [1:0] SECOND_GROUP = 2'h2; // second line starts at channel 3

	// ----------------------------------------------------------------
	// link pins sampled by the device, {cs_n, rd_n, sclk, if_sel, byte_sel, order}
	// ----------------------------------------------------------------
	localparam int DEV_SYNC_W = 6;
	localparam logic [5:0] DEV_SYNC_RST = 6'h38;
	localparam int HOST_SYNC_W = 12; // {byte_bus, out_first, out_second, flag, busy}

	// ----------------------------------------------------------------
	// readout modes, {interface_select, byte_mode_select}
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_WORD = 2'b00,
		MODE_UNUSED = 2'b01,
		MODE_SERIAL = 2'b10,
		MODE_BYTE = 2'b11
	} adr_mode_t;

	// ----------------------------------------------------------------
	// timing of the strobes the host makes
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int STROBE_HALF_NS = 64;
	localparam int STROBE_HALF_CYC = (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [6:0] XFER_BYTE = 7'h08;
	localparam logic [6:0] XFER_SER_ONE = 7'h40;
	localparam logic [6:0] XFER_SER_TWO = 7'h20;

	// ----------------------------------------------------------------
	// host buffering
	// ----------------------------------------------------------------
	localparam int FIFO_DEPTH = 16;
	localparam int FIFO_W = RES_W + 1; // {first flag, word}
endpackage : adr_pkg

`default_nettype wire

/* verilog/adr_if.sv */
// link wires between the readout port and the host that reads it
// assumes: the bench resolves each driven pin from its enable
`default_nettype none

interface adr_if;
	logic cs_n;
	logic rd_n;
	logic sclk;
	logic interface_select;
	logic byte_mode_select;
	logic byte_order_select;
	logic [7:0] byte_bus;
	logic byte_bus_oe;
	logic serial_out_first;
	logic serial_out_second;
	logic serial_oe;
	logic first_channel_flag;
	logic first_channel_flag_oe;
	logic busy;

	modport dev (
		input cs_n, rd_n, sclk, interface_select, byte_mode_select, byte_order_select,
		output byte_bus, byte_bus_oe, serial_out_first, serial_out_second, serial_oe,
		output first_channel_flag, first_channel_flag_oe, busy
	);

	modport host (
		output cs_n, rd_n, sclk, interface_select, byte_mode_select, byte_order_select,
		input byte_bus, byte_bus_oe, serial_out_first, serial_out_second, serial_oe,
		input first_channel_flag, first_channel_flag_oe, busy
	);
endinterface : adr_if

`default_nettype wire

/* verilog/adr_dev_end.sv */
// device end of the result readout port: byte-wide and serial readout
// assumes: conversion logic on clk_in gives busy and four results;
// link pins come from another domain and are synchronised here
//
// Contract
// [RL1] host sets both select pins high for bytes
// [RL2] each result leaves as two bytes
// [RL3] order pin chooses upper or lower byte first
// [RL4] chip select enables bus, read strobe steps bytes
// [RL5] host gives eight read strobes per readout
// [RL6] byte flag high for channel one bytes
// [RL7] host sets select high, byte select low
// [RL8] deselected: serial outputs off, clock ignored
// [RL9] msb at select fall, next bits on rise
// [RL10] sixteen clocks per channel, ascending, framing free
// [RL11] first line 1,2,3,4; second 3,4,1,2
// [RL12] serial flag high through channel one
// [RL13] flag also marks channel three on second
// [RL14] reads while busy give previous results
// [RL15] host deselects before busy falls
// [RL16] single line readers prefer the first line
// [RL17] results load when busy falls
// [RL18] sequence counters restart on each load
`default_nettype none

module adr_dev_end (
	input wire logic clk_in,
	input wire logic nrst_in,
	adr_if.dev link,
	input wire logic conv_busy_in,
	input wire logic [adr_pkg::NUM_CH-1:0][adr_pkg::RES_W-1:0] result_in,
	output logic results_loaded_out,
	output logic read_active_out
);
	import adr_pkg::*;

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	logic [DEV_SYNC_W-1:0] sync1_reg;
	logic [DEV_SYNC_W-1:0] sync2_reg;
	logic [DEV_SYNC_W-1:0] prev_reg;

	// two stages per pin; edges are found on the second stage only
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_reg <= DEV_SYNC_RST;
			sync2_reg <= DEV_SYNC_RST;
			prev_reg <= DEV_SYNC_RST;
		end else begin
			sync1_reg <= {link.cs_n, link.rd_n, link.sclk, link.interface_select,
				link.byte_mode_select, link.byte_order_select};
			sync2_reg <= sync1_reg;
			prev_reg <= sync2_reg;
		end
	end

	// edge and level decode of the synchronised pins
	wire cs_n_s = sync2_reg[5];
	wire cs_fall = prev_reg[5] & ~sync2_reg[5];
	wire rd_fall = prev_reg[4] & ~sync2_reg[4];
	wire sclk_fall = prev_reg[3] & ~sync2_reg[3];
	wire sclk_rise = ~prev_reg[3] & sync2_reg[3];
	wire [1:0] mode_s = sync2_reg[2:1];
	wire order_hi_first = sync2_reg[0];
	wire is_byte = (mode_s == MODE_BYTE); // [RL1]
	wire is_ser = (mode_s == MODE_SERIAL); // [RL7]
	wire selected = ~cs_n_s;
	// clock edges count only while selected
	wire byte_step = is_byte & selected & rd_fall; // [RL4]
	wire ser_step = is_ser & selected & sclk_fall; // [RL8]
	wire ser_shift = is_ser & selected & sclk_rise; // [RL8]
	wire ser_start = is_ser & cs_fall;

	// ----------------------------------------------------------------
	// result registers
	// ----------------------------------------------------------------
	logic [NUM_CH-1:0][RES_W-1:0] res_reg;
	logic conv_busy_prev_reg;
	logic busy_reg;
	logic loaded_reg;

	// the end of conversion is the busy fall
	wire load = conv_busy_prev_reg & ~conv_busy_in; // [RL17]

	// results change only at the busy fall, so reads during busy see the old set
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			res_reg <= '0;
			conv_busy_prev_reg <= 1'b0;
			busy_reg <= 1'b0;
			loaded_reg <= 1'b0;
		end else begin
			conv_busy_prev_reg <= conv_busy_in;
			busy_reg <= conv_busy_in;
			loaded_reg <= load;
			if (load) begin
				res_reg <= result_in; // [RL14] [RL17]
			end
		end
	end

	// ----------------------------------------------------------------
	// sequence counters
	// ----------------------------------------------------------------
	logic [2:0] byte_cnt_reg;
	logic [2:0] byte_cnt_next;
	logic [5:0] bit_ptr_reg;
	logic [5:0] bit_ptr_next;

	// counters survive a chip select rise, so channels may be framed one by one
	always_comb begin
		byte_cnt_next = byte_cnt_reg;
		bit_ptr_next = bit_ptr_reg;
		if (load) begin
			byte_cnt_next = BYTE_CNT_RST; // [RL18]
			bit_ptr_next = BIT_PTR_RST; // [RL18]
		end else if (byte_step) begin
			byte_cnt_next = byte_cnt_reg + 3'd1; // [RL5]
		end else if (ser_step) begin
			bit_ptr_next = bit_ptr_reg + 6'd1; // [RL10]
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			byte_cnt_reg <= BYTE_CNT_RST;
			bit_ptr_reg <= BIT_PTR_RST;
		end else begin
			byte_cnt_reg <= byte_cnt_next;
			bit_ptr_reg <= bit_ptr_next;
		end
	end

	// ----------------------------------------------------------------
	// data selection
	// ----------------------------------------------------------------
	// one bit of a channel, msb first
	function automatic logic pick_bit(
		input logic [NUM_CH-1:0][RES_W-1:0] res,
		input logic [1:0] ch,
		input logic [3:0] pos
	);
		logic [3:0] idx;
		idx = 4'hF - pos;
		pick_bit = res[ch][idx];
	endfunction : pick_bit

	// byte channel and half; the order pin flips which half goes first
	wire [1:0] byte_ch = byte_cnt_reg[2:1];
	wire take_upper = order_hi_first ^ byte_cnt_reg[0]; // [RL3]
	wire [7:0] byte_val = take_upper ? res_reg[byte_ch][15:8] : res_reg[byte_ch][7:0]; // [RL2]
	wire byte_flag = (byte_cnt_reg < BYTE_CNT_FIRST_LOW); // [RL6]

	// second line runs two channels ahead of the first
	wire [1:0] ch_first = bit_ptr_reg[5:4]; // [RL11]
	wire [1:0] ch_second = bit_ptr_reg[5:4] ^ SECOND_GROUP; // [RL11]
	wire bit_first = pick_bit(res_reg, ch_first, bit_ptr_reg[3:0]); // [RL9]
	wire bit_second = pick_bit(res_reg, ch_second, bit_ptr_reg[3:0]); // [RL9]
	// flag follows the first line, so the second line shows channel 3 with it
	wire ser_flag_now = (bit_ptr_reg[5:4] == 2'h0); // [RL12] [RL13]
	wire ser_flag_next = (bit_ptr_next[5:4] == 2'h0); // [RL12]

	// ----------------------------------------------------------------
	// byte-wide outputs
	// ----------------------------------------------------------------
	logic [7:0] bus_reg;
	logic bus_oe_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			bus_reg <= 8'h00;
			bus_oe_reg <= 1'b0;
		end else begin
			bus_oe_reg <= is_byte & selected; // [RL4]
			if (byte_step) begin
				bus_reg <= byte_val; // [RL2] [RL4]
			end
		end
	end

	// ----------------------------------------------------------------
	// serial outputs
	// ----------------------------------------------------------------
	logic so_first_reg;
	logic so_second_reg;
	logic ser_oe_reg;

	// msb goes out at the select fall, later bits on each rising clock
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			so_first_reg <= 1'b0;
			so_second_reg <= 1'b0;
			ser_oe_reg <= 1'b0;
		end else begin
			ser_oe_reg <= is_ser & selected; // [RL8]
			if (ser_start | ser_shift) begin
				so_first_reg <= bit_first; // [RL9]
				so_second_reg <= bit_second; // [RL9]
			end
		end
	end

	// ----------------------------------------------------------------
	// first-channel flag, shared by both modes
	// ----------------------------------------------------------------
	logic flag_reg;
	logic flag_oe_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			flag_reg <= 1'b0;
			flag_oe_reg <= 1'b0;
		end else begin
			flag_oe_reg <= (is_byte | is_ser) & selected; // [RL6] [RL8]
			if (is_byte & cs_fall) begin
				flag_reg <= 1'b0;
			end else if (byte_step) begin
				flag_reg <= byte_flag; // [RL6]
			end else if (ser_start) begin
				flag_reg <= ser_flag_now; // [RL12]
			end else if (ser_step) begin
				flag_reg <= ser_flag_next; // [RL12]
			end
		end
	end

	// ----------------------------------------------------------------
	// pin and user outputs
	// ----------------------------------------------------------------
	logic active_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			active_reg <= 1'b0;
		end else begin
			active_reg <= (is_byte | is_ser) & selected;
		end
	end

	assign link.byte_bus = bus_reg;
	assign link.byte_bus_oe = bus_oe_reg;
	assign link.serial_out_first = so_first_reg;
	assign link.serial_out_second = so_second_reg;
	assign link.serial_oe = ser_oe_reg;
	assign link.first_channel_flag = flag_reg;
	assign link.first_channel_flag_oe = flag_oe_reg;
	assign link.busy = busy_reg;
	assign results_loaded_out = loaded_reg;
	assign read_active_out = active_reg;
endmodule : adr_dev_end

`default_nettype wire

/* verilog/adr_host_end.sv */
// host end of the readout port: makes the strobes, collects words into a fifo
// assumes: device pins come from another domain; the user drains word_out
`default_nettype none

module adr_fifo #(
	parameter int WIDTH = adr_pkg::FIFO_W,
	parameter int DEPTH = adr_pkg::FIFO_DEPTH
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic in_valid_in,
	input wire logic [WIDTH-1:0] in_data_in,
	output logic in_ready_out,
	output logic out_valid_out,
	output logic [WIDTH-1:0] out_data_out,
	input wire logic out_ready_in
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_reg;
	logic [AW-1:0] rd_ptr_reg;
	logic [AW:0] count_reg;
	logic out_valid_reg;
	logic [WIDTH-1:0] out_data_reg;

	// handshake decode; the output register refills when empty or taken
	wire do_wr = in_valid_in & in_ready_out;
	wire do_rd = (count_reg != '0) & (~out_valid_reg | out_ready_in);
	assign in_ready_out = (count_reg != FULL_CNT);

	always_ff @(posedge clk_in) begin
		if (do_wr) begin
			mem[wr_ptr_reg] <= in_data_in;
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else begin
			wr_ptr_reg <= do_wr ? wr_ptr_reg + 1'b1 : wr_ptr_reg;
			rd_ptr_reg <= do_rd ? rd_ptr_reg + 1'b1 : rd_ptr_reg;
			count_reg <= count_reg + (AW + 1)'(do_wr) - (AW + 1)'(do_rd);
			if (do_rd) begin
				out_data_reg <= mem[rd_ptr_reg];
				out_valid_reg <= 1'b1;
			end else if (out_ready_in) begin
				out_valid_reg <= 1'b0;
			end
		end
	end

	assign out_valid_out = out_valid_reg;
	assign out_data_out = out_data_reg;
endmodule : adr_fifo

module adr_host_end (
	input wire logic clk_in,
	input wire logic nrst_in,
	adr_if.host link,
	input wire logic start_in,
	input wire logic [1:0] mode_in,
	input wire logic order_hi_first_in,
	input wire logic dual_line_in,
	output logic [adr_pkg::RES_W-1:0] word_out,
	output logic word_first_out,
	output logic word_valid_out,
	input wire logic word_ready_in,
	output logic reading_out
);
	import adr_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_LOW = 3'b010,
		ST_HIGH = 3'b011,
		ST_PUSH = 3'b100,
		ST_END = 3'b101
	} adr_hstate_t;

	// ----------------------------------------------------------------
	// synchronisers for device pins
	// ----------------------------------------------------------------
	logic [HOST_SYNC_W-1:0] sync1_reg;
	logic [HOST_SYNC_W-1:0] sync2_reg;

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end else begin
			sync1_reg <= {link.byte_bus, link.serial_out_first, link.serial_out_second,
				link.first_channel_flag, link.busy};
			sync2_reg <= sync1_reg;
		end
	end

	wire [7:0] bus_s = sync2_reg[11:4];
	wire sa_s = sync2_reg[3];
	wire sb_s = sync2_reg[2];
	wire flag_s = sync2_reg[1];
	wire busy_s = sync2_reg[0];

	// ----------------------------------------------------------------
	// strobe sequencer
	// ----------------------------------------------------------------
	adr_hstate_t state_reg;
	logic [3:0] timer_reg;
	logic [6:0] cnt_reg;
	logic [1:0] mode_reg;
	logic order_reg;
	logic dual_reg;
	logic cs_n_reg;
	logic rd_n_reg;
	logic sclk_reg;
	logic reading_reg;
	logic [15:0] sh_a_reg;
	logic [15:0] sh_b_reg;
	logic first_reg;
	logic push_b_reg;

	localparam logic [3:0] HALF_LAST = 4'(STROBE_HALF_CYC - 1);
	wire is_byte = (mode_reg == MODE_BYTE);
	wire two_lines = dual_reg & ~is_byte;
	wire [6:0] total = is_byte ? XFER_BYTE : (two_lines ? XFER_SER_TWO : XFER_SER_ONE); // [RL5] [RL10]
	wire half_done = (timer_reg == HALF_LAST);
	wire [6:0] cnt_inc = cnt_reg + 7'd1;
	wire word_done = is_byte ? cnt_reg[0] : (cnt_reg[3:0] == 4'hF);
	wire new_word = is_byte ? ~cnt_reg[0] : (cnt_reg[3:0] == 4'h0);
	// byte mode samples before the read strobe rises, serial at the clock fall
	wire sample = (state_reg == ST_LOW & half_done & is_byte) | // [RL9]
		((state_reg == ST_HIGH | state_reg == ST_SETUP) & half_done & ~is_byte);
	wire [15:0] byte_first = order_reg ? {bus_s, 8'h00} : {8'h00, bus_s};
	wire [15:0] byte_second = order_reg ? {sh_a_reg[15:8], bus_s} : {bus_s, sh_a_reg[7:0]};
	wire push_valid = (state_reg == ST_PUSH);
	wire [FIFO_W-1:0] push_data = push_b_reg ? {1'b0, sh_b_reg} : {first_reg, sh_a_reg}; // [RL16]
	wire push_ready;

	// assembly of bytes or bits into words
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sh_a_reg <= 16'h0000;
			sh_b_reg <= 16'h0000;
			first_reg <= 1'b0;
		end else if (sample) begin
			if (new_word) begin
				first_reg <= flag_s;
			end
			if (is_byte) begin
				sh_a_reg <= cnt_reg[0] ? byte_second : byte_first;
			end else begin
				sh_a_reg <= {sh_a_reg[14:0], sa_s};
				sh_b_reg <= {sh_b_reg[14:0], sb_s};
			end
		end
	end

	// reads start only with busy low, so the select fall never meets a result update
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state_reg <= ST_IDLE;
			timer_reg <= 4'h0;
			cnt_reg <= 7'h00;
			mode_reg <= MODE_SERIAL;
			order_reg <= 1'b1;
			dual_reg <= 1'b0;
			cs_n_reg <= 1'b1;
			rd_n_reg <= 1'b1;
			sclk_reg <= 1'b1;
			reading_reg <= 1'b0;
			push_b_reg <= 1'b0;
		end else begin
			timer_reg <= half_done ? 4'h0 : timer_reg + 4'd1;
			case (state_reg)
				ST_IDLE: begin
					mode_reg <= mode_in;
					order_reg <= order_hi_first_in;
					dual_reg <= dual_line_in;
					timer_reg <= 4'h0;
					if (start_in & ~busy_s & (mode_reg == MODE_BYTE | mode_reg == MODE_SERIAL)) begin // [RL15]
						cs_n_reg <= 1'b0;
						cnt_reg <= 7'h00;
						reading_reg <= 1'b1;
						state_reg <= ST_SETUP;
					end
				end
				ST_SETUP, ST_HIGH: begin
					if (half_done) begin
						if (is_byte) begin
							rd_n_reg <= 1'b0;
							state_reg <= ST_LOW;
						end else begin
							sclk_reg <= 1'b0;
							cnt_reg <= cnt_inc;
							state_reg <= word_done ? ST_PUSH : ST_LOW;
						end
					end
				end
				ST_LOW: begin
					if (half_done) begin
						if (is_byte) begin
							rd_n_reg <= 1'b1;
							cnt_reg <= cnt_inc;
							state_reg <= word_done ? ST_PUSH : ST_HIGH;
						end else begin
							sclk_reg <= 1'b1;
							state_reg <= ST_HIGH;
						end
					end
				end
				ST_PUSH: begin
					timer_reg <= 4'h0;
					if (push_ready) begin
						if (two_lines & ~push_b_reg) begin
							push_b_reg <= 1'b1;
						end else begin
							push_b_reg <= 1'b0;
							state_reg <= (cnt_reg == total) ? ST_END : (is_byte ? ST_HIGH : ST_LOW);
						end
					end
				end
				ST_END: begin
					cs_n_reg <= 1'b1;
					rd_n_reg <= 1'b1;
					sclk_reg <= 1'b1;
					reading_reg <= 1'b0;
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// word buffer; a full fifo holds the sequencer in the push state
	// ----------------------------------------------------------------
	logic [FIFO_W-1:0] fifo_out;

	adr_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) adr_fifo_inst (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.in_valid_in(push_valid),
		.in_data_in(push_data),
		.in_ready_out(push_ready),
		.out_valid_out(word_valid_out),
		.out_data_out(fifo_out),
		.out_ready_in(word_ready_in)
	);

	assign word_out = fifo_out[RES_W-1:0];
	assign word_first_out = fifo_out[RES_W];
	assign reading_out = reading_reg;
	assign link.cs_n = cs_n_reg;
	assign link.rd_n = rd_n_reg;
	assign link.sclk = sclk_reg;
	assign link.interface_select = mode_reg[1]; // [RL1] [RL7]
	assign link.byte_mode_select = mode_reg[0];
	assign link.byte_order_select = order_reg;
endmodule : adr_host_end

`default_nettype wire

/* sim/adr_link_properties.sv */
// checker for the readout link between the device end and the host end
// assumes: instantiated in the bench beside the link interface, same clock as both ends
`default_nettype none

module adr_link_properties (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic cs_n,
	input wire logic rd_n,
	input wire logic sclk,
	input wire logic interface_select,
	input wire logic byte_mode_select,
	input wire logic [7:0] byte_bus,
	input wire logic byte_bus_oe,
	input wire logic serial_out_first,
	input wire logic serial_out_second,
	input wire logic serial_oe,
	input wire logic first_channel_flag,
	input wire logic first_channel_flag_oe,
	input wire logic busy
);
	// ----------------------------------------------------------------
	// link rules, pin sync latency is about three clocks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!nrst_in);

	chk_idle_outputs_off: assert property (cs_n [*6] |-> !byte_bus_oe && !serial_oe && !first_channel_flag_oe)
		else $error("outputs driven while deselected");
	chk_one_bus_only: assert property (byte_bus_oe |-> !serial_oe)
		else $error("byte bus and serial lines driven together");
	chk_byte_holds: assert property ((!cs_n && rd_n) [*5] |-> $stable(byte_bus))
		else $error("byte bus moved without a read strobe");
	chk_bits_hold: assert property ((!cs_n && !sclk) [*5] |-> $stable({serial_out_first, serial_out_second}))
		else $error("serial bit moved while clock low");
	chk_select_drives: assert property ($fell(cs_n) && interface_select |-> ##[2:6] (byte_bus_oe || serial_oe))
		else $error("select fall did not enable outputs");
	chk_byte_flag_low: assert property ($fell(cs_n) && byte_mode_select |->
		##[2:6] (first_channel_flag_oe && !first_channel_flag))
		else $error("byte flag not low before first strobe");
	chk_serial_flag_up: assert property ($fell(cs_n) && !byte_mode_select |->
		##[2:6] (first_channel_flag_oe && first_channel_flag))
		else $error("serial flag not raised with first msb");
	chk_strobes_idle: assert property (cs_n |-> rd_n && sclk)
		else $error("strobe active outside a frame");

	// main scenarios seen
	cover property (!cs_n && byte_mode_select && first_channel_flag);
	cover property (serial_oe && first_channel_flag && !sclk);
	cover property (busy && !cs_n);
endmodule : adr_link_properties

`default_nettype wire

/* sim/tb_adr_byte_serial_readout.sv */
// self-checking bench: host end reads the device end over the link
// assumes: both ends share clk_in; results are fed straight into the device
`default_nettype none

module tb_adr_byte_serial_readout;
	timeunit 1ns;
	timeprecision 1ps;
	import adr_pkg::*;

	// ----------------------------------------------------------------
	// stimulus and wiring
	// ----------------------------------------------------------------
	logic clk_in = 1'b0;
	logic nrst_in = 1'b0;
	logic conv_busy_in = 1'b0;
	logic start_in = 1'b0;
	logic [1:0] mode_in = 2'h2;
	logic order_hi_first_in = 1'b1;
	logic dual_line_in = 1'b0;
	logic word_ready_in = 1'b0;
	logic [NUM_CH-1:0][RES_W-1:0] result_in = '0;
	logic [NUM_CH-1:0][RES_W-1:0] ra = 64'h4d4c_3c3b_2b2a_1a19;
	logic [NUM_CH-1:0][RES_W-1:0] rb = 64'hf0e1_d2c3_b4a5_9687;
	logic [RES_W-1:0] word_out;
	logic word_first_out;
	logic word_valid_out;
	logic reading_out;
	logic results_loaded_out;
	logic read_active_out;
	int failures = 0;
	int compares = 0;

	always #4 clk_in = ~clk_in;

	adr_if link ();
	adr_dev_end adr_dev_end_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link), .conv_busy_in(conv_busy_in),
		.result_in(result_in), .results_loaded_out(results_loaded_out), .read_active_out(read_active_out));
	adr_host_end adr_host_end_inst (.clk_in(clk_in), .nrst_in(nrst_in), .link(link), .start_in(start_in),
		.mode_in(mode_in), .order_hi_first_in(order_hi_first_in), .dual_line_in(dual_line_in),
		.word_out(word_out), .word_first_out(word_first_out), .word_valid_out(word_valid_out),
		.word_ready_in(word_ready_in), .reading_out(reading_out));
	adr_link_properties adr_link_properties_inst (.clk_in(clk_in), .nrst_in(nrst_in), .cs_n(link.cs_n),
		.rd_n(link.rd_n), .sclk(link.sclk), .interface_select(link.interface_select),
		.byte_mode_select(link.byte_mode_select), .byte_bus(link.byte_bus), .byte_bus_oe(link.byte_bus_oe),
		.serial_out_first(link.serial_out_first), .serial_out_second(link.serial_out_second),
		.serial_oe(link.serial_oe), .first_channel_flag(link.first_channel_flag),
		.first_channel_flag_oe(link.first_channel_flag_oe), .busy(link.busy));

	// ----------------------------------------------------------------
	// shared tasks
	// ----------------------------------------------------------------
	task automatic conclude();
		$display("counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : conclude

	task automatic miss(string m);
		failures++;
		$display("mismatch at %0t: %s", $time, m);
	endtask : miss

	// word and its first-channel mark compared as one value
	task automatic cmp(logic [RES_W:0] got, logic [RES_W:0] exp);
		compares++;
		if (got !== exp) begin
			miss($sformatf("word %h, expected %h", got, exp));
		end
	endtask : cmp

	// single status bit compare
	task automatic cmp_bit(logic got, logic exp, string m);
		compares++;
		if (got !== exp) begin
			miss(m);
		end
	endtask : cmp_bit

	// bounded wait for a level on reading_out; a hang ends the run
	task automatic wait_read(logic lvl, int lim);
		int n;
		n = 0;
		while (reading_out !== lvl) begin
			@(negedge clk_in);
			n++;
			if (n > lim) begin
				miss("wait ran out");
				conclude();
			end
		end
	endtask : wait_read

	// a busy pulse loads new results into the device on its fall
	task automatic ld(logic [NUM_CH-1:0][RES_W-1:0] r);
		@(posedge clk_in);
		result_in <= r;
		conv_busy_in <= 1'b1;
		repeat (4) @(posedge clk_in);
		conv_busy_in <= 1'b0;
		@(posedge clk_in);
		@(negedge clk_in);
		cmp_bit(results_loaded_out, 1'b1, "no load pulse");
		repeat (8) @(posedge clk_in);
	endtask : ld

	// mode is latched a cycle before start, so it is set two edges early
	task automatic rd(logic [1:0] md, logic ord, logic dual, logic bz);
		@(posedge clk_in);
		mode_in <= md;
		order_hi_first_in <= ord;
		dual_line_in <= dual;
		repeat (2) @(posedge clk_in);
		start_in <= 1'b1;
		@(posedge clk_in);
		start_in <= 1'b0;
		wait_read(1'b1, 20);
		@(posedge clk_in);
		conv_busy_in <= bz;
		repeat (4) @(negedge clk_in);
		cmp_bit(read_active_out, 1'b1, "select fall not seen");
		wait_read(1'b0, 3000);
		repeat (4) @(negedge clk_in);
		cmp_bit(read_active_out, 1'b0, "select rise not seen");
	endtask : rd

	// takes one word out of the fifo; ready is held only for that word
	task automatic pop(logic [NUM_CH-1:0][RES_W-1:0] r, logic [1:0] c, logic f);
		int n;
		n = 0;
		@(posedge clk_in);
		word_ready_in <= 1'b1;
		@(negedge clk_in);
		while (word_valid_out !== 1'b1) begin
			@(negedge clk_in);
			n++;
			if (n > 40) begin
				miss("no word");
				conclude();
			end
		end
		cmp({word_first_out, word_out}, {f, r[c]});
		@(posedge clk_in);
		word_ready_in <= 1'b0;
	endtask : pop

	// four words, channel indices packed two bits each, first word marked
	task automatic popn(logic [NUM_CH-1:0][RES_W-1:0] r, logic [7:0] seq);
		for (int k = 0; k < 4; k++) begin
			pop(r, seq[2*k +: 2], k == 0);
		end
	endtask : popn

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	task automatic t_byte();
		ld(ra);
		rd(2'h3, 1'b1, 1'b0, 1'b0);
		popn(ra, 8'he4);
		rd(2'h3, 1'b0, 1'b0, 1'b0);
		popn(ra, 8'he4);
		$display("test byte done");
	endtask : t_byte

	task automatic t_serial();
		ld(rb);
		rd(2'h2, 1'b1, 1'b0, 1'b0);
		popn(rb, 8'he4);
		ld(ra);
		rd(2'h2, 1'b1, 1'b1, 1'b0);
		popn(ra, 8'hd8);
		$display("test serial done");
	endtask : t_serial

	// busy rises mid-read with new results waiting; old ones must come out
	task automatic t_busy();
		ld(ra);
		@(posedge clk_in);
		result_in <= rb;
		rd(2'h2, 1'b1, 1'b0, 1'b1);
		popn(ra, 8'he4);
		@(posedge clk_in);
		conv_busy_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		rd(2'h2, 1'b1, 1'b0, 1'b0);
		popn(rb, 8'he4);
		$display("test busy done");
	endtask : t_busy

	// four reads with nobody draining queue sixteen words: fifteen in fifo memory, one in its output register
	task automatic t_fifo();
		ld(rb);
		repeat (4) rd(2'h3, 1'b1, 1'b0, 1'b0);
		repeat (4) popn(rb, 8'he4);
		$display("test fifo done");
	endtask : t_fifo

	initial begin
		repeat (20) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		t_byte();
		t_serial();
		t_busy();
		t_fifo();
		conclude();
	end
endmodule : tb_adr_byte_serial_readout

`default_nettype wire
